// ==== core/lpx_ext_mode.sv ====
// Overview of operation
// - Mode-register-set bank bits 00 pick base register, 10 extended; 01 and 11 reserved.
// - Extended register holds its contents until rewritten or power is lost.
// - Bits four and three choose temperature range; self-refresh rate follows it.
// - Unchanged temperature field means 85 degrees and fastest self-refresh rate.
// - Coverage picks all banks, banks 0-1, bank 0, half or quarter bank 0.
// - Normal accesses reach every bank; self refresh refreshes only covered region.
// - Two-bank option loses banks 2-3; one-bank option loses banks 1-3.
// - Bits five and six set data pin drive level; default full strength.
// - Shutdown entered on CKE low, banks idle, CS and WE low, RAS CAS high.
// - Shutdown ends when CKE is raised.
// - Entering shutdown loses all stored data.
// - Unwritten register means full-array refresh, full drive, 85-degree temperature range.
`timescale 1ns/1ps
`default_nettype none
`include "lpx_regs.svh"

module lpx_ext_mode
    import lpx_pkg::*;
#(
    parameter int BANKS = 4
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    input  wire logic                  mem_cke,
    input  wire lpx_pkg::lpx_cmd_t     mem_cmd,
    output lpx_pkg::lpx_settings_t     settings,
    output logic [11:0]                low_power_extension_settings,
    output logic [11:0]                base_operation_settings,
    output lpx_pkg::lpx_state_t        power_state,
    output logic                       array_shutdown_mode,
    output logic                       sr_tick,
    output logic [BANKS-1:0]           sr_bank_mask,
    output logic [BANKS-1:0]           bank_open,
    output logic [BANKS-1:0]           data_lost,
    output logic                       mrs_busy,
    output logic                       init_required,
    output logic                       cmd_ignored,
    output logic                       protocol_error
);
    import lpx_pkg::*;

    lpx_state_t     state_q;
    lpx_op_t        op;
    logic           cke_prev_q;
    logic [11:0]    ext_q;
    logic [11:0]    base_q;
    logic [8:0]     burst_left_q;
    logic [15:0]    sr_cnt_q;
    logic [15:0]    sr_ivl;
    logic           sr_tick_q;
    logic [11:0]    off_wait_q;
    logic [1:0]     mrs_wait_q;
    logic           init_req_q;
    logic           ignored_q;
    logic           err_q;
    logic           live;
    logic           all_idle;
    logic           mrs_ext;
    logic           mrs_base;
    logic           mrs_rsvd;
    logic           ext_wr;
    logic           sr_entry;
    logic           off_entry;
    logic [BANKS-1:0] cover_mask;
    logic [BANKS-1:0] lose_mask;

    // Command decode; a command counts only if CKE was high at the previous edge, except shutdown entry
    always_comb
    begin
        op = LPX_OP_NOP;
        if (!mem_cmd.cs_n)
        begin
            unique case ({mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n})
                3'b011: op = LPX_OP_ACT;
                3'b101: op = LPX_OP_READ;
                3'b100: op = LPX_OP_WRITE;
                3'b010: op = LPX_OP_PRE;
                3'b001: op = LPX_OP_REF;
                3'b000: op = LPX_OP_MRS;
                3'b110: op = LPX_OP_BST;
                3'b111: op = LPX_OP_NOP;
            endcase
        end
    end

    assign live      = clk_en && cke_prev_q && mem_cke && (state_q == LPX_NORMAL);
    assign all_idle  = (bank_open == '0) && (burst_left_q == 9'h000);
    assign mrs_ext   = live && (op == LPX_OP_MRS) && (mem_cmd.ba == `LPX_BA_EXT);
    assign mrs_base  = live && (op == LPX_OP_MRS) && (mem_cmd.ba == `LPX_BA_BASE);
    assign mrs_rsvd  = live && (op == LPX_OP_MRS) && mem_cmd.ba[0];
    assign ext_wr    = mrs_ext && all_idle;
    assign sr_entry  = clk_en && cke_prev_q && !mem_cke && (state_q == LPX_NORMAL)
                       && (op == LPX_OP_REF) && all_idle;
    assign off_entry = clk_en && !mem_cke && (state_q == LPX_NORMAL) && all_idle
                       && (op == LPX_OP_BST);

    // Banks kept alive during self refresh for each coverage code
    always_comb
    begin
        unique case (ext_q[`LPX_COVER_MSB:`LPX_COVER_LSB])
            `LPX_COVER_TWO:     cover_mask = 4'h3;
            `LPX_COVER_ONE,
            `LPX_COVER_HALF,
            `LPX_COVER_QUARTER: cover_mask = 4'h1;
            default:            cover_mask = 4'hf;
        endcase
    end

    // Self-refresh interval follows the temperature range
    always_comb
    begin
        unique case (ext_q[`LPX_TEMP_MSB:`LPX_TEMP_LSB])
            `LPX_TEMP_70C: sr_ivl = `LPX_SR_IVL_70C;
            `LPX_TEMP_45C: sr_ivl = `LPX_SR_IVL_45C;
            `LPX_TEMP_15C: sr_ivl = `LPX_SR_IVL_15C;
            `LPX_TEMP_85C: sr_ivl = `LPX_SR_IVL_85C;
        endcase
    end

    // Uncovered banks are lost on self-refresh entry, all banks on shutdown entry
    assign lose_mask = off_entry ? {BANKS{1'b1}} :
                       sr_entry  ? ~cover_mask : '0;

    lpx_bank_tracker #(
        .BANKS     (BANKS)
    ) u_banks (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .act_valid (live && (op == LPX_OP_ACT)),
        .pre_valid (live && (op == LPX_OP_PRE)),
        .pre_all   (mem_cmd.addr[10]),
        .wr_valid  (live && (op == LPX_OP_WRITE)),
        .bank      (mem_cmd.ba),
        .lose_mask (lose_mask),
        .bank_open (bank_open),
        .data_lost (data_lost)
    );

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            cke_prev_q <= 1'b0;
        else if (clk_en)
            cke_prev_q <= mem_cke;
    end

    // Extended register: reserved bits are stored as zero
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            ext_q <= `LPX_EXT_RESET;
        else if (clk_en && ext_wr)
            ext_q <= mem_cmd.addr & ~`LPX_RSVD_MASK;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            base_q <= `LPX_BASE_RESET;
        else if (clk_en && mrs_base && all_idle)
            base_q <= mem_cmd.addr;
    end

    // Burst tracking so that register writes can be refused mid-burst
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            burst_left_q <= 9'h000;
        else if (clk_en)
        begin
            if (live && ((op == LPX_OP_READ) || (op == LPX_OP_WRITE)))
            begin
                unique case (base_q[`LPX_BL_MSB:`LPX_BL_LSB])
                    3'h0:    burst_left_q <= 9'h001;
                    3'h1:    burst_left_q <= 9'h002;
                    3'h2:    burst_left_q <= 9'h004;
                    3'h3:    burst_left_q <= 9'h008;
                    default: burst_left_q <= `LPX_BL_FULL_PAGE;
                endcase
            end
            else if (live && ((op == LPX_OP_BST) || (op == LPX_OP_PRE)))
                burst_left_q <= 9'h000;
            else if (burst_left_q != 9'h000)
                burst_left_q <= burst_left_q - 9'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            state_q <= LPX_NORMAL;
        else if (clk_en)
        begin
            unique case (state_q)
                LPX_NORMAL:
                begin
                    if (off_entry)
                        state_q <= LPX_SHUTDOWN;
                    else if (sr_entry)
                        state_q <= LPX_SELF_REFRESH;
                end
                LPX_SELF_REFRESH:
                begin
                    if (mem_cke)
                        state_q <= LPX_NORMAL;
                end
                LPX_SHUTDOWN:
                begin
                    if (mem_cke)
                        state_q <= LPX_NORMAL;
                end
            endcase
        end
    end

    // Self-refresh oscillator
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sr_cnt_q  <= 16'h0000;
            sr_tick_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sr_tick_q <= 1'b0;
            if (state_q != LPX_SELF_REFRESH)
                sr_cnt_q <= 16'h0000;
            else if (sr_cnt_q >= sr_ivl - 16'h0001)
            begin
                sr_cnt_q  <= 16'h0000;
                sr_tick_q <= 1'b1;
            end
            else
                sr_cnt_q <= sr_cnt_q + 16'h0001;
        end
    end

    // Shutdown exit quiet period and the need for a fresh initialization
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            off_wait_q <= 12'h000;
            init_req_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if ((state_q == LPX_SHUTDOWN) && mem_cke)
            begin
                off_wait_q <= 12'(`LPX_OFF_EXIT_CYC);
                init_req_q <= 1'b1;
            end
            else
            begin
                if (off_wait_q != 12'h000)
                    off_wait_q <= off_wait_q - 12'h001;
                if (ext_wr && (off_wait_q == 12'h000))
                    init_req_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            mrs_wait_q <= 2'h0;
        else if (clk_en)
        begin
            if (ext_wr || (mrs_base && all_idle))
                mrs_wait_q <= 2'(`LPX_MRS_RECOVERY_CYC);
            else if (mrs_wait_q != 2'h0)
                mrs_wait_q <= mrs_wait_q - 2'h1;
        end
    end

    // Misuse is flagged; writes with reserved bits set and commands inside a wait period still act
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ignored_q <= 1'b0;
            err_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            ignored_q <= (state_q == LPX_SHUTDOWN) && !mem_cke
                         && (op != LPX_OP_NOP);
            err_q     <= mrs_rsvd
                         || (mrs_ext && !all_idle)
                         || (mrs_ext && ((mem_cmd.addr & `LPX_RSVD_MASK) != 12'h000))
                         || (live && (op != LPX_OP_NOP) && (mrs_wait_q != 2'h0))
                         || (live && (op != LPX_OP_NOP) && (off_wait_q != 12'h000))
                         || ((state_q == LPX_SHUTDOWN) && cke_prev_q && mem_cke);
        end
    end

    assign low_power_extension_settings       = ext_q;
    assign base_operation_settings            = base_q;
    assign settings.output_drive_level        = ext_q[`LPX_DRIVE_MSB:`LPX_DRIVE_LSB];
    assign settings.temp_scaled_refresh_rate  = ext_q[`LPX_TEMP_MSB:`LPX_TEMP_LSB];
    assign settings.partial_refresh_coverage  = ext_q[`LPX_COVER_MSB:`LPX_COVER_LSB];
    assign power_state                        = state_q;
    assign array_shutdown_mode                = (state_q == LPX_SHUTDOWN);
    assign sr_tick                            = sr_tick_q;
    assign sr_bank_mask = (state_q == LPX_SELF_REFRESH) ? cover_mask : '0;
    assign mrs_busy                           = (mrs_wait_q != 2'h0);
    assign init_required                      = init_req_q;
    assign cmd_ignored                        = ignored_q;
    assign protocol_error                     = err_q;

    chk_ext_write_taken: assert property (@(posedge clk_sys) disable iff (!resetn)
        ext_wr |=> ext_q == ($past(mem_cmd.addr) & ~`LPX_RSVD_MASK))
        else $error("extended write not stored");

    chk_reserved_bank_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
        mrs_rsvd |=> $stable(ext_q) && $stable(base_q) && err_q)
        else $error("reserved bank select changed a register");

    chk_ext_hold_value: assert property (@(posedge clk_sys) disable iff (!resetn)
        !ext_wr |=> $stable(ext_q))
        else $error("extended register changed without a write");

    chk_busy_write_refused: assert property (@(posedge clk_sys) disable iff (!resetn)
        (mrs_ext && !all_idle) |=> $stable(ext_q) && err_q)
        else $error("write during activity not refused");

    chk_fast_refresh_rate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && state_q == LPX_SELF_REFRESH && sr_tick_q
         && ext_q[4:3] == `LPX_TEMP_85C) ##1 (clk_en && state_q == LPX_SELF_REFRESH)[*8]
        |-> !sr_tick_q)
        else $error("self-refresh tick too early");

    chk_cover_mask_map: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_q == LPX_SELF_REFRESH && ext_q[2:0] == `LPX_COVER_TWO)
        |-> sr_bank_mask == 4'h3)
        else $error("coverage mask wrong");

    chk_bank_loss_two: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sr_entry && ext_q[2:0] == `LPX_COVER_TWO) |=> data_lost[3] && data_lost[2])
        else $error("banks two and three not marked lost");

    chk_drive_default: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> settings.output_drive_level == `LPX_DRIVE_FULL
                          && sr_ivl == `LPX_SR_IVL_85C)
        else $error("reset defaults wrong");

    chk_shutdown_entry: assert property (@(posedge clk_sys) disable iff (!resetn)
        off_entry |=> array_shutdown_mode && data_lost == 4'hf)
        else $error("shutdown not entered or data kept");

    chk_shutdown_exit: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && array_shutdown_mode && mem_cke) |=> !array_shutdown_mode
        ##0 init_required)
        else $error("shutdown exit missed");

    chk_shutdown_ignore: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && array_shutdown_mode && !mem_cke && op == LPX_OP_ACT)
        |=> cmd_ignored && array_shutdown_mode && $stable(bank_open))
        else $error("command acted on in shutdown");

endmodule : lpx_ext_mode

`default_nettype wire

// ==== core/lpx_regs.svh ====
`ifndef LPX_REGS_SVH
`define LPX_REGS_SVH

// Bank-address selection during a mode-register-set command
`define LPX_BA_BASE          2'b00
`define LPX_BA_EXT           2'b10

// Reset contents of the two mode registers
`define LPX_BASE_RESET       12'h000
`define LPX_EXT_RESET        12'h018

// Field positions inside the extended register
`define LPX_COVER_LSB        0
`define LPX_COVER_MSB        2
`define LPX_TEMP_LSB         3
`define LPX_TEMP_MSB         4
`define LPX_DRIVE_LSB        5
`define LPX_DRIVE_MSB        6
`define LPX_RSVD_LSB         7
`define LPX_RSVD_MSB         11
`define LPX_RSVD_MASK        12'hf80

// Field encodings
`define LPX_TEMP_70C         2'b00
`define LPX_TEMP_45C         2'b01
`define LPX_TEMP_15C         2'b10
`define LPX_TEMP_85C         2'b11
`define LPX_COVER_ALL        3'h0
`define LPX_COVER_TWO        3'h1
`define LPX_COVER_ONE        3'h2
`define LPX_COVER_HALF       3'h5
`define LPX_COVER_QUARTER    3'h6
`define LPX_DRIVE_FULL       2'b00

// Burst length field of the base register
`define LPX_BL_LSB           0
`define LPX_BL_MSB           2
`define LPX_BL_FULL_PAGE     9'h100

// Timing
`define LPX_CLK_MHZ          10
`define LPX_CLK_PERIOD_NS    100
`define LPX_OFF_EXIT_US      200
`define LPX_OFF_EXIT_CYC     (`LPX_OFF_EXIT_US * `LPX_CLK_MHZ)
`define LPX_MRS_RECOVERY_NS  20
`define LPX_MRS_RECOVERY_CYC \
    ((`LPX_MRS_RECOVERY_NS + `LPX_CLK_PERIOD_NS - 1) / `LPX_CLK_PERIOD_NS)

// Self-refresh interval per temperature range, in clock cycles
`define LPX_SR_IVL_85C       16'd156
`define LPX_SR_IVL_70C       16'd312
`define LPX_SR_IVL_45C       16'd624
`define LPX_SR_IVL_15C       16'd1248

`endif

// ==== core/lpx_pkg.sv ====
package lpx_pkg;

    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [11:0] addr;
    } lpx_cmd_t;

    typedef struct packed {
        logic [1:0] output_drive_level;
        logic [1:0] temp_scaled_refresh_rate;
        logic [2:0] partial_refresh_coverage;
    } lpx_settings_t;

    typedef enum logic [1:0] {
        LPX_NORMAL,
        LPX_SELF_REFRESH,
        LPX_SHUTDOWN
    } lpx_state_t;

    typedef enum logic [2:0] {
        LPX_OP_NOP,
        LPX_OP_ACT,
        LPX_OP_READ,
        LPX_OP_WRITE,
        LPX_OP_PRE,
        LPX_OP_REF,
        LPX_OP_MRS,
        LPX_OP_BST
    } lpx_op_t;

endpackage : lpx_pkg

// ==== core/lpx_bank_tracker.sv ====
`timescale 1ns/1ps
`default_nettype none

module lpx_bank_tracker
    import lpx_pkg::*;
#(
    parameter int BANKS = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic             act_valid,
    input  wire logic             pre_valid,
    input  wire logic             pre_all,
    input  wire logic             wr_valid,
    input  wire logic [1:0]       bank,
    input  wire logic [BANKS-1:0] lose_mask,
    output logic      [BANKS-1:0] bank_open,
    output logic      [BANKS-1:0] data_lost
);

    genvar gi;
    generate
        for (gi = 0; gi < BANKS; gi++)
        begin : g_bank
            logic hit;
            assign hit = (bank == 2'(gi));

            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                    bank_open[gi] <= 1'b0;
                else if (clk_en)
                begin
                    if (act_valid && hit)
                        bank_open[gi] <= 1'b1;
                    else if (pre_valid && (pre_all || hit))
                        bank_open[gi] <= 1'b0;
                end
            end

            // Loss wins over a fresh write in the same cycle
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                    data_lost[gi] <= 1'b0;
                else if (clk_en)
                begin
                    if (lose_mask[gi])
                        data_lost[gi] <= 1'b1;
                    else if (wr_valid && hit)
                        data_lost[gi] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : lpx_bank_tracker

`default_nettype wire

// ==== testbench/lpx_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lpx_regs.svh"

module lpx_ctrl_model (
    input  wire logic              clk_sys,
    input  wire logic              mrs_busy,
    output var  logic              mem_cke,
    output var  lpx_pkg::lpx_cmd_t mem_cmd
);
    import lpx_pkg::*;

    initial
    begin
        mem_cke = 1'b1;
        mem_cmd = 18'h1c000;
    end

    // One command for one edge, then NOP; CKE stays where it was set
    task automatic issue(input logic [3:0] op, input logic [1:0] ba, input logic [11:0] a,
                         input logic cke);
        @(posedge clk_sys);
        #10;
        mem_cke = cke;
        mem_cmd = {op, ba, a};
        @(posedge clk_sys);
        #10;
        mem_cmd = 18'h1c000;
    endtask : issue

    // Mode write, then wait up to 8 cycles for mrs_busy to clear; callers keep bits 11:7 zero except on purpose
    task automatic mrs(input logic [1:0] ba, input logic [11:0] a);
        issue(4'b0000, ba, a, 1'b1);
        for (int i = 0; i < 8 && mrs_busy !== 1'b0; i++)
        begin
            @(posedge clk_sys);
            #10;
        end
    endtask : mrs

    // Running clock with NOP only after leaving shutdown
    task automatic quiet;
        repeat (`LPX_OFF_EXIT_CYC + 4) @(posedge clk_sys);
    endtask : quiet
endmodule : lpx_ctrl_model
`default_nettype wire

// ==== testbench/sdram_ext_mode_low_power_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module sdram_ext_mode_low_power_test;
    import lpx_pkg::*;

    typedef struct packed {
        logic [1:0]  ba;
        logic [11:0] addr;
        logic [11:0] ext;
        logic [11:0] base;
        logic        err;
    } lpx_row_t;

    logic          clk_sys;
    logic          resetn;
    logic          clk_en;
    logic          mem_cke;
    lpx_cmd_t      mem_cmd;
    lpx_settings_t settings;
    logic [11:0]   ext;
    logic [11:0]   base;
    lpx_state_t    power_state;
    logic          shut;
    logic          sr_tick;
    logic [3:0]    sr_bank_mask;
    logic [3:0]    bank_open;
    logic [3:0]    data_lost;
    logic          mrs_busy;
    logic          init_req;
    logic          cmd_ignored;
    logic          protocol_error;
    logic          perr_seen;
    logic          ign_seen;
    int            bad_count;
    int            cmp_count;
    int            cycles;
    int            n;
    lpx_row_t      rows [8];

    lpx_ext_mode lpx_ext_mode_i (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .mem_cke(mem_cke),
        .mem_cmd(mem_cmd), .settings(settings), .low_power_extension_settings(ext),
        .base_operation_settings(base), .power_state(power_state),
        .array_shutdown_mode(shut), .sr_tick(sr_tick), .sr_bank_mask(sr_bank_mask),
        .bank_open(bank_open), .data_lost(data_lost), .mrs_busy(mrs_busy),
        .init_required(init_req), .cmd_ignored(cmd_ignored), .protocol_error(protocol_error)
    );

    lpx_ctrl_model lpx_ctrl_model_i (
        .clk_sys(clk_sys), .mrs_busy(mrs_busy), .mem_cke(mem_cke), .mem_cmd(mem_cmd)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic step;
        @(posedge clk_sys);
        #10;
    endtask : step

    // Catch one-cycle pulses and cut a hang short
    always @(posedge clk_sys)
    begin
        if (protocol_error === 1'b1)
            perr_seen = 1'b1;
        if (cmd_ignored === 1'b1)
            ign_seen = 1'b1;
        cycles++;
        if (cycles == 12000)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        resetn = 1'b0;
        clk_en = 1'b1;
        bad_count = 0;
        cmp_count = 0;
        cycles = 0;
        perr_seen = 1'b0;
        ign_seen = 1'b0;
        rows = '{'{2'b10, 12'h009, 12'h009, 12'h000, 1'b0},
                 '{2'b10, 12'h012, 12'h012, 12'h000, 1'b0},
                 '{2'b10, 12'h03d, 12'h03d, 12'h000, 1'b0},
                 '{2'b00, 12'h020, 12'h03d, 12'h020, 1'b0},
                 '{2'b01, 12'h055, 12'h03d, 12'h020, 1'b1},
                 '{2'b11, 12'h055, 12'h03d, 12'h020, 1'b1},
                 '{2'b10, 12'h066, 12'h066, 12'h020, 1'b0},
                 '{2'b10, 12'hf8d, 12'h00d, 12'h020, 1'b1}};
        repeat (12) @(posedge clk_sys);
        #10;
        resetn = 1'b1;
        repeat (2) step();
        check(ext, 12'h018);
        check({5'h00, settings}, 12'h018);
        foreach (rows[i])
        begin
            perr_seen = 1'b0;
            lpx_ctrl_model_i.mrs(rows[i].ba, rows[i].addr);
            repeat (2) step();
            check(ext, rows[i].ext);
            check(base, rows[i].base);
            check({5'h00, settings}, {5'h00, rows[i].ext[6:0]});
            check({11'h000, perr_seen}, {11'h000, rows[i].err});
        end
        // Self refresh over banks 0 and 1 at the 85C rate
        lpx_ctrl_model_i.mrs(2'b10, 12'h019);
        lpx_ctrl_model_i.issue(4'b0001, 2'b00, 12'h000, 1'b0);
        check({10'h000, power_state}, {10'h000, LPX_SELF_REFRESH});
        check({4'h0, sr_bank_mask, data_lost}, 12'h03c);
        for (n = 0; n < 2000 && sr_tick !== 1'b1; n++)
            step();
        n = 0;
        do
        begin
            step();
            n++;
        end
        while (sr_tick !== 1'b1 && n < 2000);
        check(n[11:0], 12'h09c);
        lpx_ctrl_model_i.issue(4'b0111, 2'b00, 12'h000, 1'b1);
        check({10'h000, power_state}, {10'h000, LPX_NORMAL});
        lpx_ctrl_model_i.issue(4'b0011, 2'b10, 12'h000, 1'b1);
        check({8'h00, bank_open}, 12'h004);
        lpx_ctrl_model_i.issue(4'b0100, 2'b10, 12'h000, 1'b1);
        check({8'h00, data_lost}, 12'h008);
        lpx_ctrl_model_i.issue(4'b0010, 2'b00, 12'h400, 1'b1);
        // Shutdown, a command that must be ignored, then exit
        lpx_ctrl_model_i.issue(4'b0110, 2'b00, 12'h000, 1'b0);
        check({7'h00, shut, data_lost}, 12'h01f);
        ign_seen = 1'b0;
        lpx_ctrl_model_i.issue(4'b0101, 2'b00, 12'h000, 1'b0);
        step();
        check({10'h000, ign_seen, shut}, 12'h003);
        lpx_ctrl_model_i.issue(4'b0111, 2'b00, 12'h000, 1'b1);
        check({9'h000, power_state, init_req}, 12'h001);
        lpx_ctrl_model_i.quiet();
        lpx_ctrl_model_i.issue(4'b0000, 2'b10, 12'h018, 1'b1);
        check({10'h000, mrs_busy, init_req}, 12'h002);
        step();
        check({11'h000, mrs_busy}, 12'h000);
        // Clock enable low freezes the block, so this write must not land
        clk_en = 1'b0;
        lpx_ctrl_model_i.mrs(2'b10, 12'h012);
        clk_en = 1'b1;
        check(ext, 12'h018);
        // Extended write with a bank open is refused
        lpx_ctrl_model_i.issue(4'b0011, 2'b00, 12'h000, 1'b1);
        check({8'h00, bank_open}, 12'h001);
        perr_seen = 1'b0;
        lpx_ctrl_model_i.mrs(2'b10, 12'h000);
        step();
        check({perr_seen, ext[10:0]}, 12'h818);
        lpx_ctrl_model_i.issue(4'b0010, 2'b00, 12'h400, 1'b1);
        close_out();
    end
endmodule : sdram_ext_mode_low_power_test
`default_nettype wire
